// ==== rtl/bridge_extended_config_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bridge_ext_consts.svh"

// Functional notes
// RL1 - Five-bit first-error pointer at bits 4:0, zero after reset, upper bits zero.
// RL2 - On a logged error, attribute nibble and 32 data bits go to log bits 35:0.
// RL3 - First address phase command nibble goes to log bits 39:36.
// RL4 - Dual-address second phase command nibble goes to log bits 43:40.
// RL5 - First address phase address goes to log bits 95:64.
// RL6 - Dual-address second address goes to bits 127:96; bits 63:44 read zero.
// RL7 - Log fields are read-only and survive the ordinary reset.
// RL8 - Capability header: ID 0002h, version 1h, next offset zero.
// RL9 - VC0 control fixed: TC0 mapped, 7Fh in bits 7:1, enable bit 31 set.
// RL10 - Ones in GPIO bits 2:0 clear output values of pins 4 to 6.
// RL11 - Ones in GPIO bits 5:3 set output values of pins 4 to 6.
// RL12 - Ones in GPIO bits 8:6 clear pin enables; enables clear at reset.
// RL13 - Ones in GPIO bits 11:9 set pin enables.
// RL14 - Reads show sampled pins at 14:12 and extra inputs at 19:16.
// RL15 - Extra outputs: bits 3:0 clear, bits 7:4 set; reset to zero.
// RL16 - Extra enables: bits 11:8 clear, bits 15:12 set; reset to zero.
// RL17 - Replay timer value bits 11:0 reset 115h, enable bit 12 reset zero.
// RL18 - Ack latency value bits 29:16 reset CDh, enable bit 30 reset zero.
// RL19 - Zero bits leave set/clear state alone; pins driven only while enabled.
// RL20 - Reserved offsets and bits read zero and ignore writes.
module bridge_extended_config_regs (
    // Clock, resets and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic sticky_rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Error logging port
    input wire logic log_valid,
    input wire bridge_ext_pkg::log_entry_type log_in,
    // Extended GPIO pins 4 to 6
    input wire logic [2:0] ext_gpio_in,
    output logic [2:0] ext_gpio_out,
    output logic [2:0] ext_gpio_oe,
    // Extra outputs and inputs
    input wire logic [3:0] extra_gpi,
    output logic [3:0] extra_gpo,
    output logic [3:0] extra_gpo_oe,
    // Timer settings to the link layer
    output var bridge_ext_pkg::timers_type timers
);
    import bridge_ext_pkg::*;

    log_entry_type log_r;
    logic [4:0] first_err_r;
    logic [2:0] eg_val_r;
    logic [2:0] eg_oe_r;
    logic [2:0] eg_in_r;
    logic [3:0] xg_val_r;
    logic [3:0] xg_oe_r;
    logic [3:0] xg_in_r;
    timers_type timers_r;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic addr_take;
    logic rd_req;
    logic wr_hit;

    // Zero-based word compare of a bus address against an offset
    function automatic logic at_off(input logic [11:0] a, input logic [11:0] off);
        at_off = (a[11:2] == off[11:2]);
    endfunction : at_off

    // Set/clear update: clear first, set wins on a bit written both ways
    function automatic logic [3:0] set_clr(input logic [3:0] cur, input logic [3:0] clr,
                                           input logic [3:0] set);
        set_clr = (cur & ~clr) | set;
    endfunction : set_clr

    // Read multiplexer; anything not decoded reads zero
    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (at_off(a, `OFF_SEC_ERR)) begin
            w[4:0] = first_err_r; // RL1
        end else if (at_off(a, `OFF_HLOG0)) begin
            w = log_r.attr_ad; // RL2
        end else if (at_off(a, `OFF_HLOG1)) begin
            w[3:0] = log_r.attr_cbe; // RL2
            w[7:4] = log_r.cmd_lo; // RL3
            w[11:8] = log_r.cmd_hi; // RL4
        end else if (at_off(a, `OFF_HLOG2)) begin
            w = log_r.addr_lo; // RL5
        end else if (at_off(a, `OFF_HLOG3)) begin
            w = log_r.addr_hi; // RL6
        end else if (at_off(a, `OFF_VC_HDR)) begin
            w = {`VC_NEXT_OFF, `VC_CAP_VER, `VC_CAP_ID}; // RL8
        end else if (at_off(a, `OFF_VC0_CTL)) begin
            w[0] = `VC0_TC0_MAP; // RL9
            w[7:1] = `VC0_TC71_MAP; // RL9
            w[31] = `VC0_ENABLE; // RL9
        end else if (at_off(a, `OFF_EXT_GPIO)) begin
            w[`EG_CLR_LSB +: 3] = eg_val_r;
            w[`EG_SET_LSB +: 3] = eg_val_r;
            w[`EG_OECLR_LSB +: 3] = eg_oe_r;
            w[`EG_OESET_LSB +: 3] = eg_oe_r;
            w[`EG_IN_LSB +: 3] = eg_in_r; // RL14
        end else if (at_off(a, `OFF_XTRA_GPIO)) begin
            w[`XG_CLR_LSB +: 4] = xg_val_r;
            w[`XG_SET_LSB +: 4] = xg_val_r;
            w[`XG_OECLR_LSB +: 4] = xg_oe_r;
            w[`XG_OESET_LSB +: 4] = xg_oe_r;
            w[`XG_IN_LSB +: 4] = xg_in_r; // RL14
        end else if (at_off(a, `OFF_TIMERS)) begin
            w[`TM_REPLAY_LSB +: 12] = timers_r.replay_val;
            w[`TM_REPLAY_EN_BIT] = timers_r.replay_en;
            w[`TM_ACK_LSB +: 14] = timers_r.ack_val;
            w[`TM_ACK_EN_BIT] = timers_r.ack_en;
        end else begin
            w = 32'h0000_0000; // RL20
        end
        read_word = w;
    endfunction : read_word

    // Bus decode; a read right behind a write waits one cycle for the write
    assign rd_req = hsel && htrans[1] && !hwrite;
    assign hreadyout = ce && !(wr_pend_r && rd_req);
    assign addr_take = hsel && htrans[1] && hready && ce;
    assign wr_hit = wr_pend_r && ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Address phase capture for writes
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (ce) begin
            wr_pend_r <= addr_take && hwrite;
            if (addr_take && hwrite) begin
                wr_addr_r <= haddr;
            end
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata_r <= read_word(haddr);
        end
    end

    // Sticky header log, cleared only by the sticky reset
    always_ff @(posedge clk) begin
        if (sticky_rst) begin
            log_r <= '0; // RL7
        end else if (ce && log_valid) begin
            log_r.attr_cbe <= log_in.attr_cbe; // RL2
            log_r.attr_ad <= log_in.attr_ad; // RL2
            log_r.cmd_lo <= log_in.cmd_lo; // RL3
            log_r.cmd_hi <= log_in.dac ? log_in.cmd_hi : 4'h0; // RL4
            log_r.addr_lo <= log_in.addr_lo; // RL5
            log_r.addr_hi <= log_in.dac ? log_in.addr_hi : 32'h0000_0000; // RL6
            log_r.dac <= log_in.dac;
            log_r.first_err <= log_in.first_err;
        end
    end

    // First-error pointer, zero after the ordinary reset
    always_ff @(posedge clk) begin
        if (srst) begin
            first_err_r <= 5'h00;
        end else if (ce && log_valid) begin
            first_err_r <= log_in.first_err; // RL1
        end
    end

    // Extended GPIO pins: set/clear on value and enable
    always_ff @(posedge clk) begin
        if (srst) begin
            eg_val_r <= 3'h0;
            eg_oe_r <= 3'h0; // RL12
        end else if (wr_hit && at_off(wr_addr_r, `OFF_EXT_GPIO)) begin
            eg_val_r <= 3'(set_clr({1'b0, eg_val_r}, {1'b0, hwdata[`EG_CLR_LSB +: 3]}, // RL10
                                   {1'b0, hwdata[`EG_SET_LSB +: 3]})); // RL11
            eg_oe_r <= 3'(set_clr({1'b0, eg_oe_r}, {1'b0, hwdata[`EG_OECLR_LSB +: 3]}, // RL12
                                  {1'b0, hwdata[`EG_OESET_LSB +: 3]})); // RL13
        end
    end

    // Extra outputs: set/clear on value and enable
    always_ff @(posedge clk) begin
        if (srst) begin
            xg_val_r <= 4'h0;
            xg_oe_r <= 4'h0;
        end else if (wr_hit && at_off(wr_addr_r, `OFF_XTRA_GPIO)) begin
            xg_val_r <= set_clr(xg_val_r, hwdata[`XG_CLR_LSB +: 4], hwdata[`XG_SET_LSB +: 4]); // RL15
            xg_oe_r <= set_clr(xg_oe_r, hwdata[`XG_OECLR_LSB +: 4], hwdata[`XG_OESET_LSB +: 4]); // RL16
        end
    end

    // Input sampling for readback
    always_ff @(posedge clk) begin
        if (srst) begin
            eg_in_r <= 3'h0;
            xg_in_r <= 4'h0;
        end else if (ce) begin
            eg_in_r <= ext_gpio_in; // RL14
            xg_in_r <= extra_gpi; // RL14
        end
    end

    // Replay and acknowledge latency timer settings
    always_ff @(posedge clk) begin
        if (srst) begin
            timers_r.replay_val <= `TM_REPLAY_RST; // RL17
            timers_r.replay_en <= 1'b0;
            timers_r.ack_val <= `TM_ACK_RST; // RL18
            timers_r.ack_en <= 1'b0;
        end else if (wr_hit && at_off(wr_addr_r, `OFF_TIMERS)) begin
            timers_r.replay_val <= hwdata[`TM_REPLAY_LSB +: 12]; // RL17
            timers_r.replay_en <= hwdata[`TM_REPLAY_EN_BIT]; // RL17
            timers_r.ack_val <= hwdata[`TM_ACK_LSB +: 14]; // RL18
            timers_r.ack_en <= hwdata[`TM_ACK_EN_BIT]; // RL18
        end
    end

    // Pins carry their value only while enabled
    assign ext_gpio_out = eg_val_r & eg_oe_r; // RL19
    assign ext_gpio_oe = eg_oe_r;
    assign extra_gpo = xg_val_r & xg_oe_r; // RL19
    assign extra_gpo_oe = xg_oe_r;
    assign timers = timers_r;

    // Helper: address of the read now in its data phase
    logic rd_pend_r;
    logic [11:0] rd_addr_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 12'h000;
        end else if (ce) begin
            rd_pend_r <= addr_take && !hwrite;
            rd_addr_r <= haddr;
        end
    end

    // Checks
    property p_fep_reset;
        @(posedge clk) disable iff (srst) $fell(srst) |-> first_err_r == 5'h00 && hrdata == 32'h0;
    endproperty
    a_fep_reset: assert property (p_fep_reset) else $error("pointer not zero after reset"); // RL1

    property p_log_attr;
        @(posedge clk) disable iff (srst || sticky_rst)
            ce && log_valid |=> log_r.attr_ad == $past(log_in.attr_ad) && log_r.attr_cbe == $past(log_in.attr_cbe);
    endproperty
    a_log_attr: assert property (p_log_attr) else $error("attribute phase not logged"); // RL2

    property p_log_lo;
        @(posedge clk) disable iff (srst || sticky_rst)
            ce && log_valid |=> log_r.cmd_lo == $past(log_in.cmd_lo) && log_r.addr_lo == $past(log_in.addr_lo);
    endproperty
    a_log_lo: assert property (p_log_lo) else $error("first address phase not logged"); // RL5

    property p_log_sac;
        @(posedge clk) disable iff (srst || sticky_rst)
            ce && log_valid && !log_in.dac |=> log_r.cmd_hi == 4'h0 && log_r.addr_hi == 32'h0;
    endproperty
    a_log_sac: assert property (p_log_sac) else $error("upper log fields not zero"); // RL6

    property p_sticky;
        @(posedge clk) disable iff (sticky_rst) srst && !log_valid |=> $stable(log_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("log lost on ordinary reset"); // RL7

    property p_vc_hdr;
        @(posedge clk) disable iff (srst) rd_pend_r && at_off(rd_addr_r, `OFF_VC_HDR) |-> hrdata == 32'h0001_0002;
    endproperty
    a_vc_hdr: assert property (p_vc_hdr) else $error("capability header wrong"); // RL8

    property p_vc0_ctl;
        @(posedge clk) disable iff (srst) rd_pend_r && at_off(rd_addr_r, `OFF_VC0_CTL) |-> hrdata == 32'h8000_00FF;
    endproperty
    a_vc0_ctl: assert property (p_vc0_ctl) else $error("VC0 control wrong"); // RL9

    property p_gpio_clr;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_EXT_GPIO) && hwdata[2:0] == 3'h7 && hwdata[5:3] == 3'h0
            |=> eg_val_r == 3'h0;
    endproperty
    a_gpio_clr: assert property (p_gpio_clr) else $error("GPIO clear failed"); // RL10

    property p_gpio_set;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_EXT_GPIO) && hwdata[5:3] == 3'h7 |=> eg_val_r == 3'h7;
    endproperty
    a_gpio_set: assert property (p_gpio_set) else $error("GPIO set failed"); // RL11

    property p_drive;
        @(posedge clk) disable iff (srst) (ext_gpio_out & ~ext_gpio_oe) == 3'h0 && (extra_gpo & ~extra_gpo_oe) == 4'h0;
    endproperty
    a_drive: assert property (p_drive) else $error("pin driven while disabled"); // RL19

    property p_timer_reset;
        @(posedge clk) disable iff (srst)
            $fell(srst) |-> timers.replay_val == 12'h115 && timers.ack_val == 14'h00CD && !timers.replay_en;
    endproperty
    a_timer_reset: assert property (p_timer_reset) else $error("timer reset values wrong"); // RL17

    property p_unmapped;
        @(posedge clk) disable iff (srst) rd_pend_r && at_off(rd_addr_r, 12'h14C) |-> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("reserved offset not zero"); // RL20

    property p_log_dac;
        @(posedge clk) disable iff (srst || sticky_rst)
            ce && log_valid && log_in.dac
            |=> log_r.cmd_hi == $past(log_in.cmd_hi) && log_r.addr_hi == $past(log_in.addr_hi);
    endproperty
    a_log_dac: assert property (p_log_dac) else $error("second address phase not logged"); // RL4

    property p_eg_oe;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_EXT_GPIO)
            |=> (eg_oe_r & $past(hwdata[11:9])) == $past(hwdata[11:9])
                && (eg_oe_r & $past(hwdata[8:6] & ~hwdata[11:9])) == 3'h0;
    endproperty
    a_eg_oe: assert property (p_eg_oe) else $error("GPIO enable set or clear failed"); // RL13

    property p_oe_reset;
        @(posedge clk) srst |=> ext_gpio_oe == 3'h0 && extra_gpo_oe == 4'h0;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("enables not cleared by reset"); // RL12

    property p_xg_val;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_XTRA_GPIO)
            |=> (xg_val_r & $past(hwdata[7:4])) == $past(hwdata[7:4])
                && (xg_val_r & $past(hwdata[3:0] & ~hwdata[7:4])) == 4'h0;
    endproperty
    a_xg_val: assert property (p_xg_val) else $error("extra output set or clear failed"); // RL15

    property p_xg_oe;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_XTRA_GPIO)
            |=> (xg_oe_r & $past(hwdata[15:12])) == $past(hwdata[15:12])
                && (xg_oe_r & $past(hwdata[11:8] & ~hwdata[15:12])) == 4'h0;
    endproperty
    a_xg_oe: assert property (p_xg_oe) else $error("extra enable set or clear failed"); // RL16

    property p_xg_hold;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_XTRA_GPIO) && hwdata[15:0] == 16'h0000
            |=> $stable(xg_val_r) && $stable(xg_oe_r);
    endproperty
    a_xg_hold: assert property (p_xg_hold) else $error("zero write changed extra outputs"); // RL19

    property p_in_sample;
        @(posedge clk) disable iff (srst)
            ce && !srst |=> eg_in_r == $past(ext_gpio_in) && xg_in_r == $past(extra_gpi);
    endproperty
    a_in_sample: assert property (p_in_sample) else $error("input sample lost"); // RL14

    property p_timer_ack;
        @(posedge clk) disable iff (srst)
            wr_hit && at_off(wr_addr_r, `OFF_TIMERS)
            |=> timers.ack_val == $past(hwdata[29:16]) && timers.ack_en == $past(hwdata[30]);
    endproperty
    a_timer_ack: assert property (p_timer_ack) else $error("acknowledge timer write lost"); // RL18

    c_log_dac: cover property (@(posedge clk) disable iff (srst) ce && log_valid && log_in.dac);
    c_rd_after_wr: cover property (@(posedge clk) disable iff (srst) wr_pend_r && rd_req && !hreadyout);
    c_pin_driven: cover property (@(posedge clk) disable iff (srst) ext_gpio_out == 3'h7);
    c_timer_wr: cover property (@(posedge clk) disable iff (srst) wr_hit && at_off(wr_addr_r, `OFF_TIMERS));

endmodule : bridge_extended_config_regs
`default_nettype wire

// ==== rtl/bridge_ext_consts.svh ====
`ifndef BRIDGE_EXT_CONSTS_SVH
`define BRIDGE_EXT_CONSTS_SVH

// Register byte offsets within the extended space
`define OFF_SEC_ERR 12'h138
`define OFF_HLOG0 12'h13C
`define OFF_HLOG1 12'h140
`define OFF_HLOG2 12'h144
`define OFF_HLOG3 12'h148
`define OFF_VC_HDR 12'h150
`define OFF_PVC_CAP1 12'h154
`define OFF_PVC_CAP2 12'h158
`define OFF_PVC_CTL 12'h15C
`define OFF_VC0_CAP 12'h160
`define OFF_VC0_CTL 12'h164
`define OFF_VC0_STS 12'h168
`define OFF_EXT_GPIO 12'h300
`define OFF_XTRA_GPIO 12'h304
`define OFF_TIMERS 12'h310

// Fixed capability words
`define VC_CAP_ID 16'h0002
`define VC_CAP_VER 4'h1
`define VC_NEXT_OFF 12'h000
`define VC0_TC0_MAP 1'b1
`define VC0_TC71_MAP 7'h7F
`define VC0_ENABLE 1'b1

// Field positions in the extended GPIO word
`define EG_CLR_LSB 0
`define EG_SET_LSB 3
`define EG_OECLR_LSB 6
`define EG_OESET_LSB 9
`define EG_IN_LSB 12

// Field positions in the extra GPI/GPO word
`define XG_CLR_LSB 0
`define XG_SET_LSB 4
`define XG_OECLR_LSB 8
`define XG_OESET_LSB 12
`define XG_IN_LSB 16

// Timer word fields and reset values
`define TM_REPLAY_LSB 0
`define TM_REPLAY_EN_BIT 12
`define TM_ACK_LSB 16
`define TM_ACK_EN_BIT 30
`define TM_REPLAY_RST 12'h115
`define TM_ACK_RST 14'h00CD

`endif

// ==== rtl/bridge_ext_pkg.sv ====
package bridge_ext_pkg;

    // One captured secondary-bus transaction
    typedef struct packed {
        logic [4:0] first_err;
        logic dac;
        logic [3:0] attr_cbe;
        logic [31:0] attr_ad;
        logic [3:0] cmd_lo;
        logic [3:0] cmd_hi;
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
    } log_entry_type;

    // Link-layer timer settings
    typedef struct packed {
        logic [11:0] replay_val;
        logic replay_en;
        logic [13:0] ack_val;
        logic ack_en;
    } timers_type;

endpackage : bridge_ext_pkg

// ==== tb/bridge_extended_config_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bridge_ext_consts.svh"
module bridge_extended_config_regs_test;
    import bridge_ext_pkg::*;
    // Bench signals
    logic clk, srst, sticky_rst, ce, hsel, hwrite, hreadyout, hresp, log_valid;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, w;
    logic [2:0] ext_gpio_in, ext_gpio_out, ext_gpio_oe, gv_r, goe_r;
    logic [3:0] extra_gpi, extra_gpo, extra_gpo_oe, xv_r, xoe_r;
    logic [127:0] wide;
    log_entry_type log_in, e;
    timers_type timers;
    logic [31:0] lfsr_r = 32'h0000003F;
    int err_total = 0;
    int cmp_count = 0;
    // Device under test, single slave so hreadyout is the bus hready
    bridge_extended_config_regs dut_u (.clk(clk), .srst(srst), .sticky_rst(sticky_rst), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .log_valid(log_valid), .log_in(log_in), .ext_gpio_in(ext_gpio_in), .ext_gpio_out(ext_gpio_out),
        .ext_gpio_oe(ext_gpio_oe), .extra_gpi(extra_gpi), .extra_gpo(extra_gpo),
        .extra_gpo_oe(extra_gpo_oe), .timers(timers));
    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Verdict and end of run
    task automatic close_out;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Thirty-two shift steps per draw
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        for (int i = 0; i < 32; i++) begin
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
        return s;
    endfunction : lfsr_next
    // Expected read words
    function automatic logic [31:0] eg_exp(input logic [2:0] v, input logic [2:0] oe, input logic [2:0] pin);
        return {17'h0, pin, oe, oe, v, v};
    endfunction : eg_exp
    function automatic logic [31:0] xg_exp(input logic [3:0] v, input logic [3:0] oe, input logic [3:0] pin);
        return {12'h0, pin, oe, oe, v, v};
    endfunction : xg_exp
    function automatic logic [31:0] fixed_exp(input logic [11:0] a);
        if (a == 12'h150) return 32'h00010002;
        if (a == 12'h164) return 32'h800000FF;
        return 32'h0;
    endfunction : fixed_exp
    function automatic logic [31:0] log_word(input log_entry_type le, input int i);
        case (i)
            0: return le.attr_ad;
            1: return {20'h0, le.dac ? le.cmd_hi : 4'h0, le.cmd_lo, le.attr_cbe};
            2: return le.addr_lo;
            default: return le.dac ? le.addr_hi : 32'h0;
        endcase
    endfunction : log_word
    // Wait for hready under a bound
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        chk({31'h0, hresp}, 32'h0);
        if (n >= 20) chk({31'h0, hreadyout}, 32'h1);
    endtask : wait_ready
    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // Write whose data phase carries the read address phase of the same word
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b1;
        wait_ready();
        hwrite <= 1'b0;
        hwdata <= wd;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        rd = hrdata;
    endtask : wr_rd
    // Fixed words and reserved offsets
    task automatic check_fixed;
        logic [11:0] fa [14] = '{12'h150, 12'h154, 12'h158, 12'h15C, 12'h160, 12'h164, 12'h168,
                                12'h14C, 12'h16C, 12'h2FC, 12'h308, 12'h30C, 12'h314, 12'hFFC};
        foreach (fa[i]) begin
            bus(1'b0, fa[i], 32'h0);
            chk(rd, fixed_exp(fa[i]));
        end
    endtask : check_fixed
    task automatic check_log(input log_entry_type le);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 12'h13C + 12'(4 * i), 32'h0);
            chk(rd, log_word(le, i));
        end
    endtask : check_log
    // State loaded by the ordinary reset
    task automatic check_reset;
        gv_r = 3'h0;
        goe_r = 3'h0;
        xv_r = 4'h0;
        xoe_r = 4'h0;
        bus(1'b0, 12'h138, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 12'h300, 32'h0);
        chk(rd, eg_exp(3'h0, 3'h0, ext_gpio_in));
        bus(1'b0, 12'h304, 32'h0);
        chk(rd, xg_exp(4'h0, 4'h0, extra_gpi));
        bus(1'b0, 12'h310, 32'h0);
        chk(rd, 32'h00CD0115);
        chk({4'h0, timers}, {4'h0, 12'h115, 1'b0, 14'h00CD, 1'b0});
        chk({18'h0, ext_gpio_out, ext_gpio_oe, extra_gpo, extra_gpo_oe}, 32'h0);
    endtask : check_reset
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
    // Main sequence
    initial begin
        {srst, sticky_rst, ce} = 3'b111;
        {hsel, hwrite, log_valid, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        log_in = '0;
        ext_gpio_in = 3'h5;
        extra_gpi = 4'hA;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        sticky_rst <= 1'b0;
        check_reset();
        check_fixed();
        check_log('0);
        // Logged transactions, single and dual address
        for (int k = 0; k < 4; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wide[127:96] = lfsr_r;
            lfsr_r = lfsr_next(lfsr_r);
            wide[95:64] = lfsr_r;
            lfsr_r = lfsr_next(lfsr_r);
            wide[63:32] = lfsr_r;
            lfsr_r = lfsr_next(lfsr_r);
            wide[31:0] = lfsr_r;
            e = wide[113:0];
            e.dac = k[0];
            log_in <= e;
            log_valid <= 1'b1;
            @(posedge clk);
            log_valid <= 1'b0;
            bus(1'b0, 12'h138, 32'h0);
            chk(rd, {27'h0, e.first_err});
            check_log(e);
        end
        // Writes to read-only places are ignored
        for (int i = 0; i < 5; i++) bus(1'b1, 12'h138 + 12'(4 * i), 32'hFFFFFFFF);
        for (int i = 0; i < 12; i++) bus(1'b1, 12'h14C + 12'(4 * i), 32'hFFFFFFFF);
        check_fixed();
        check_log(e);
        bus(1'b0, 12'h138, 32'h0);
        chk(rd, {27'h0, e.first_err});
        // Set and clear fields; zero, then the extended GPIO word's set-all and clear-all corners first
        for (int k = 0; k < 16; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            ext_gpio_in <= lfsr_r[22:20];
            extra_gpi <= lfsr_r[27:24];
            w = (k == 0) ? 32'h0 : (k == 1) ? 32'h00000E38 : (k == 2) ? 32'h000001C7 : lfsr_next(lfsr_r);
            gv_r = (gv_r & ~w[2:0]) | w[5:3];
            goe_r = (goe_r & ~w[8:6]) | w[11:9];
            bus(1'b1, 12'h300, w);
            bus(1'b0, 12'h300, 32'h0);
            chk(rd, eg_exp(gv_r, goe_r, ext_gpio_in));
            chk({26'h0, ext_gpio_out, ext_gpio_oe}, {26'h0, gv_r & goe_r, goe_r});
            xv_r = (xv_r & ~w[3:0]) | w[7:4];
            xoe_r = (xoe_r & ~w[11:8]) | w[15:12];
            bus(1'b1, 12'h304, w);
            bus(1'b0, 12'h304, 32'h0);
            chk(rd, xg_exp(xv_r, xoe_r, extra_gpi));
            chk({24'h0, extra_gpo, extra_gpo_oe}, {24'h0, xv_r & xoe_r, xoe_r});
        end
        // Timer word
        for (int k = 0; k < 8; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            w = lfsr_r;
            wr_rd(12'h310, w);
            chk(rd, w & 32'h7FFF1FFF);
            chk({4'h0, timers}, {4'h0, w[11:0], w[12], w[29:16], w[30]});
        end
        // Clock enable low holds the bus off and blocks a log capture
        ce <= 1'b0;
        log_in <= ~e;
        log_valid <= 1'b1;
        @(posedge clk);
        chk({31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        log_valid <= 1'b0;
        // Mid-run ordinary reset leaves the log alone
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        check_reset();
        check_log(e);
        sticky_rst <= 1'b1;
        @(posedge clk);
        sticky_rst <= 1'b0;
        check_log('0);
        close_out();
    end
endmodule : bridge_extended_config_regs_test
`default_nettype wire
